// *** logic/ldcl_pkg.sv ***
// constants, types and register map of the led driver diagnostic link
package ldcl_pkg;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_PULSE_NS = 300;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_RST_NS = 200;
  localparam int SOFT_RST_CYC = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // fault persistence
  localparam int CNT_W = 9;
  localparam logic [8:0] FAULT_PULSES = 9'h1fc;
  // serial commands, first bit on the line is the msb
  localparam logic [15:0] CMD_F_NORM = 16'hf777;
  localparam logic [15:0] CMD_F_M20 = 16'hf111;
  localparam logic [15:0] CMD_F_M40 = 16'hf333;
  localparam logic [15:0] CMD_CH1_OFF = 16'hf555;
  // fault patterns in priority order: ch1 ov, ch2 ov, ch1 uv, ch2 uv
  localparam logic [15:0] PAT_TABLE = 16'h7531;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FILT = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int CTRL_CLR_BIT = 0;
  localparam int STAT_PAT_LSB = 0;
  localparam int STAT_PVAL_BIT = 4;
  localparam int STAT_FREQ_LSB = 5;
  localparam int STAT_CH1OFF_BIT = 7;
  localparam int STAT_PGOOD_BIT = 8;
  localparam int STAT_OT_BIT = 9;
  localparam int STAT_ACT_BIT = 10;
  localparam int STAT_IDX_LSB = 11;

  typedef enum logic [1:0] {LDCL_F_NORM, LDCL_F_M20, LDCL_F_M40} ldcl_freq_t;

  // asynchronous pin levels and analog comparator flags
  typedef struct packed {
    logic dim_ch1_in;
    logic dim_ch2_in;
    logic diag;
    logic en;
    logic vcc_ok;
    logic tsd;
    logic ot;
    logic pgood;
    logic ov1;
    logic ov2;
    logic uv1;
    logic uv2;
  } ldcl_pins_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } ldcl_av_req_t;
endpackage

// *** logic/ldcl_sync3.sv ***
// three-stage synchroniser whose output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ldcl_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: a glitch seen by one stage only never reaches q
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= (s2_q & s3_q) | (q & (s2_q | s3_q));
    end
  end
endmodule // ldcl_sync3
`default_nettype wire

// *** logic/ldcl_top.sv ***
// supervisory logic of a two-channel led driver: diagnostic line, dimming gates, enable reset
// Operation
// - diagnostic line is open-drain: the device only ever pulls it low
// - serial bits latch on each falling edge of channel-1 dimming, even with channel 1 off
// - power-good and over-temperature appear as static line levels
// - a constant channel-1 dimming level moves no serial bit
// - enable low clears fault reports, pattern, frequency tuning and channel-1 shutoff
// - a 200 ns enable low pulse is a soft reset of reports and commands
// - operation and soft-start only start once supply leaves lockout
// - lockout, thermal shutdown or enable low ground the ramp node
// - thermal shutdown disables the device and regulator until it releases
// - each channel sinks current only while its own dimming input is high
// - channels follow dimming pulses down to 300 ns
// - after power-good, 16-bit commands set normal, minus 20 or minus 40 percent
// - channel-1 shutoff command; all commands refused under over-temperature or pattern
// - faults show as repeated four-bit patterns until cleared
// - fault needs 508 consecutive pulses; over-temperature hides the pattern meanwhile
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ldcl_top #(
  parameter logic [8:0] FILT_RESET = ldcl_pkg::FAULT_PULSES
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SRST,
  // pins and analog flags, asynchronous
  input wire ldcl_pkg::ldcl_pins_t PINS,
  // diagnostic line drive, open-drain
  output logic DIAG_OUT,
  output logic DIAG_OE,
  // power stage control
  output logic CH1_SINK,
  output logic CH2_SINK,
  output logic RAMP_GND,
  output logic LDO_ON,
  output ldcl_pkg::ldcl_freq_t FREQ_SEL,
  // avalon-mm slave
  input wire ldcl_pkg::ldcl_av_req_t AV_REQ,
  output logic [31:0] AV_READDATA,
  output logic AV_WAITREQUEST
);
  import ldcl_pkg::*;

  localparam int PULSE_LIM = MIN_PULSE_CYC;

  ldcl_pins_t pins_s;
  logic dim_ch1_in_prev_q;
  logic dim_ch2_in_prev_q;
  logic fall1;
  logic fall2;
  logic active;
  logic clr;
  logic sw_clr_q;
  logic [8:0] filt_q;
  logic [CNT_W-1:0] cnt_q [4];
  logic [3:0] cond;
  logic [3:0] fall_v;
  logic [3:0] hit;
  logic [3:0] pat_q;
  logic pat_valid_q;
  logic [1:0] idx_q;
  logic [15:0] cmd_sh_q;
  logic [15:0] cmd_next;
  logic cmd_ok;
  logic ch1_off_q;
  ldcl_freq_t freq_q;
  logic oe_d;
  logic [31:0] stat_word;

  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c, input logic f,
                                                 input logic k, input logic [8:0] thr);
    logic [CNT_W-1:0] r;
    r = c;
    if (f) begin
      if (!k) begin
        r = '0;
      end else if (c < thr) begin
        r = c + 1'b1;
      end
    end
    return r;
  endfunction

  // all pins pass four flops before use
  ldcl_sync3 #(.W($bits(ldcl_pins_t))) u_sync (
    .clk(REF_CLK),
    .srst(SRST),
    .d(PINS),
    .q(pins_s)
  );

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      dim_ch1_in_prev_q <= 1'b0;
      dim_ch2_in_prev_q <= 1'b0;
    end else begin
      dim_ch1_in_prev_q <= pins_s.dim_ch1_in;
      dim_ch2_in_prev_q <= pins_s.dim_ch2_in;
    end
  end

  // one latch event per filtered falling edge; a steady level gives none
  assign fall1 = dim_ch1_in_prev_q & ~pins_s.dim_ch1_in;
  assign fall2 = dim_ch2_in_prev_q & ~pins_s.dim_ch2_in;

  assign active = pins_s.en & pins_s.vcc_ok & ~pins_s.tsd;
  // any shutdown cause, or the software clear, wipes reports and commands
  assign clr = ~active | sw_clr_q;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      LDO_ON <= 1'b0;
      RAMP_GND <= 1'b1;
    end else begin
      LDO_ON <= active;
      RAMP_GND <= ~active;
    end
  end

  // dimming gates follow within a few cycles, far below the shortest pulse
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CH1_SINK <= 1'b0;
      CH2_SINK <= 1'b0;
    end else begin
      CH1_SINK <= active & pins_s.dim_ch1_in & ~ch1_off_q;
      CH2_SINK <= active & pins_s.dim_ch2_in;
    end
  end

  // fault persistence counters: ch1 ov, ch2 ov, ch1 uv, ch2 uv
  assign cond = {pins_s.uv2, pins_s.uv1, pins_s.ov2, pins_s.ov1};
  assign fall_v = {fall2, fall1, fall2, fall1};

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (clr) begin
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_step(cnt_q[i], fall_v[i], cond[i], filt_q);
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hit[i] = fall_v[i] & cond[i] & (cnt_q[i] == filt_q - 9'h001);
    end
  end

  // a later fault replaces the shown one; over-temperature leaves it intact
  // a fault latched in the cycle of a software clear wins, so it is never lost
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      pat_q <= 4'h0;
      pat_valid_q <= 1'b0;
      idx_q <= 2'h0;
    end else if (!active || (sw_clr_q && !(|hit))) begin
      pat_q <= 4'h0;
      pat_valid_q <= 1'b0;
      idx_q <= 2'h0;
    end else if (|hit) begin
      pat_valid_q <= 1'b1;
      idx_q <= 2'h0;
      if (hit[0]) begin
        pat_q <= PAT_TABLE[3:0];
      end else if (hit[1]) begin
        pat_q <= PAT_TABLE[7:4];
      end else if (hit[2]) begin
        pat_q <= PAT_TABLE[11:8];
      end else begin
        pat_q <= PAT_TABLE[15:12];
      end
    end else if (pat_valid_q && fall1) begin
      idx_q <= idx_q + 2'h1;
    end
  end

  // command receiver, sampled at channel-1 falling edges
  assign cmd_next = {cmd_sh_q[14:0], pins_s.diag};
  assign cmd_ok = active & pins_s.pgood & ~pins_s.ot & ~pat_valid_q;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      cmd_sh_q <= 16'h0000;
    end else if (clr) begin
      cmd_sh_q <= 16'h0000;
    end else if (fall1) begin
      case (cmd_next)
        CMD_F_NORM, CMD_F_M20, CMD_F_M40, CMD_CH1_OFF: cmd_sh_q <= 16'h0000;
        default: cmd_sh_q <= cmd_next;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      freq_q <= LDCL_F_NORM;
      ch1_off_q <= 1'b0;
    end else if (clr) begin
      freq_q <= LDCL_F_NORM;
      ch1_off_q <= 1'b0;
    end else if (fall1 && cmd_ok) begin
      case (cmd_next)
        CMD_F_NORM: freq_q <= LDCL_F_NORM;
        CMD_F_M20: freq_q <= LDCL_F_M20;
        CMD_F_M40: freq_q <= LDCL_F_M40;
        CMD_CH1_OFF: ch1_off_q <= 1'b1;
        default: ch1_off_q <= ch1_off_q;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      FREQ_SEL <= LDCL_F_NORM;
    end else begin
      FREQ_SEL <= freq_q;
    end
  end

  // line drive: over-temperature wins over serial pattern bits, which win over the power-good level
  always_comb begin
    if (pins_s.ot) begin
      oe_d = 1'b1;
    end else if (pat_valid_q) begin
      oe_d = ~pat_q[2'h3 - idx_q];
    end else begin
      oe_d = ~pins_s.pgood;
    end
  end

  // the data level is never driven high; the far end supplies the pull-up
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      DIAG_OUT <= 1'b0;
      DIAG_OE <= 1'b1;
    end else begin
      DIAG_OUT <= 1'b0;
      DIAG_OE <= oe_d;
    end
  end

  // avalon slave: one wait cycle, then the answer
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[STAT_PAT_LSB +: 4] = pat_q;
    stat_word[STAT_PVAL_BIT] = pat_valid_q;
    stat_word[STAT_FREQ_LSB +: 2] = freq_q;
    stat_word[STAT_CH1OFF_BIT] = ch1_off_q;
    stat_word[STAT_PGOOD_BIT] = pins_s.pgood;
    stat_word[STAT_OT_BIT] = pins_s.ot;
    stat_word[STAT_ACT_BIT] = active;
    stat_word[STAT_IDX_LSB +: 2] = idx_q;
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      AV_WAITREQUEST <= 1'b1;
    end else if ((AV_REQ.read || AV_REQ.write) && AV_WAITREQUEST) begin
      AV_WAITREQUEST <= 1'b0;
    end else begin
      AV_WAITREQUEST <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      AV_READDATA <= 32'h0000_0000;
    end else if (AV_REQ.read && AV_WAITREQUEST) begin
      case (AV_REQ.address)
        REG_FILT: AV_READDATA <= {23'h000000, filt_q};
        REG_STAT: AV_READDATA <= stat_word;
        default: AV_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // writes take effect on the edge that completes the transfer
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      filt_q <= FILT_RESET;
      sw_clr_q <= 1'b0;
    end else begin
      sw_clr_q <= 1'b0;
      if (AV_REQ.write && !AV_WAITREQUEST) begin
        case (AV_REQ.address)
          REG_CTRL: sw_clr_q <= AV_REQ.writedata[CTRL_CLR_BIT];
          REG_FILT: filt_q <= (AV_REQ.writedata[8:0] == 9'h000) ? 9'h001 : AV_REQ.writedata[8:0];
          default: filt_q <= filt_q;
        endcase
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  property p_bit_adv;
    $changed(idx_q) && $past(pat_valid_q) && pat_valid_q && !$rose(pat_valid_q) |-> $past(fall1 || (|hit));
  endproperty
  a_bit_adv: assert property (p_bit_adv) else $error("pattern bit moved without a falling edge");

  property p_static_ot;
    pins_s.ot ##1 pins_s.ot |-> DIAG_OE;
  endproperty
  a_static_ot: assert property (p_static_ot) else $error("line not low under over-temperature");

  property p_no_xfer;
    $stable(pins_s.dim_ch1_in) && !clr |=> $stable(cmd_sh_q);
  endproperty
  a_no_xfer: assert property (p_no_xfer) else $error("serial bit moved without dimming edge");

  property p_en_clear;
    !pins_s.en |=> !pat_valid_q && freq_q == LDCL_F_NORM && !ch1_off_q;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enable low did not clear state");

  property p_ramp;
    !active |=> RAMP_GND && !LDO_ON;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp node not grounded in shutdown");

  property p_tsd;
    pins_s.tsd |=> !LDO_ON && !CH1_SINK && !CH2_SINK;
  endproperty
  a_tsd: assert property (p_tsd) else $error("thermal shutdown left device running");

  property p_ch2;
    CH2_SINK |-> $past(pins_s.dim_ch2_in);
  endproperty
  a_ch2: assert property (p_ch2) else $error("channel 2 sinks without its dimming input");

  property p_follow;
    $rose(pins_s.dim_ch1_in) && active && !ch1_off_q ##1 pins_s.dim_ch1_in && active |-> ##[0:PULSE_LIM] CH1_SINK;
  endproperty
  a_follow: assert property (p_follow) else $error("channel 1 missed a dimming pulse");

  property p_refuse;
    (pins_s.ot || pat_valid_q) && !clr |=> !$rose(ch1_off_q) && $stable(freq_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("command taken while refused");

  property p_fault;
    $rose(pat_valid_q) |-> $past(|hit);
  endproperty
  a_fault: assert property (p_fault) else $error("pattern set without persistence count");

  c_pattern: cover property ($rose(pat_valid_q));
  c_ch1_off: cover property ($rose(ch1_off_q));
  c_freq40: cover property (freq_q == LDCL_F_M40);
  c_sw_clear: cover property (sw_clr_q && pat_valid_q);
endmodule // ldcl_top
`default_nettype wire

// *** verif/ldcl_mcu_model.sv ***
// far-side controller model: drives the dimming clock and talks on the diagnostic line
`timescale 1ns/1ps
`default_nettype none
module ldcl_mcu_model (
  // clock
  input wire logic clk,
  // link
  input wire logic line,
  output logic dim_ch1_in,
  output logic dim_ch2_in,
  output logic pull_low
);
  logic tie2 = 1'b1;
  logic dim_ch2_in_lvl = 1'b0;

  initial begin
    dim_ch1_in = 1'b0;
    pull_low = 1'b0;
  end

  assign dim_ch2_in = tie2 ? dim_ch1_in : dim_ch2_in_lvl;

  // high phase kept at 300 ns, so the link runs slower than it could
  task automatic slot(input logic b, output logic s);
    @(posedge clk);
    pull_low <= ~b;
    dim_ch1_in <= 1'b1;
    repeat (29) @(posedge clk);
    // sample late: a weak pull-up makes the line rise slowly
    s = line;
    @(posedge clk);
    dim_ch1_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic send(input logic [15:0] w);
    logic s;
    for (int i = 15; i >= 0; i--) slot(w[i], s);
    @(posedge clk);
    pull_low <= 1'b0;
  endtask

  task automatic recv(input int n, output logic [7:0] r);
    logic s;
    r = '0;
    for (int i = 0; i < n; i++) begin
      slot(1'b1, s);
      r = {r[6:0], s};
    end
  endtask
endmodule // ldcl_mcu_model
`default_nettype wire

// *** verif/test_led_driver_diag_command_link.sv ***
// self-checking bench of the diagnostic link and supervisory logic
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_led_driver_diag_command_link;
  import ldcl_pkg::*;
  logic REF_CLK = 1'b0;
  logic SRST = 1'b1;
  ldcl_pins_t ctl = '0;
  ldcl_pins_t pins;
  ldcl_av_req_t av = '0;
  logic DIAG_OUT, DIAG_OE, CH1_SINK, CH2_SINK, RAMP_GND, LDO_ON, AV_WAITREQUEST;
  ldcl_freq_t FREQ_SEL;
  logic [31:0] AV_READDATA;
  logic [31:0] rd;
  logic dim_ch1_in, dim_ch2_in, pull_low, line;
  logic [7:0] r;
  int n_errors = 0;
  int n_tests = 0;
  logic [3:0] pat [4] = '{4'h1, 4'h3, 4'h5, 4'h7};
  logic [15:0] cmd [3] = '{16'hf111, 16'hf333, 16'hf777};
  ldcl_freq_t fexp [3] = '{LDCL_F_M20, LDCL_F_M40, LDCL_F_NORM};

  always #5 REF_CLK = ~REF_CLK;

  // the controller side supplies the only pull-up of the line
  assign line = ~DIAG_OE & ~pull_low;
  always_comb begin
    pins = ctl;
    pins.dim_ch1_in = dim_ch1_in;
    pins.dim_ch2_in = dim_ch2_in;
    pins.diag = line;
  end

  ldcl_top DUT (.REF_CLK(REF_CLK), .SRST(SRST), .PINS(pins), .DIAG_OUT(DIAG_OUT), .DIAG_OE(DIAG_OE),
    .CH1_SINK(CH1_SINK), .CH2_SINK(CH2_SINK), .RAMP_GND(RAMP_GND), .LDO_ON(LDO_ON), .FREQ_SEL(FREQ_SEL),
    .AV_REQ(av), .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST));
  ldcl_mcu_model mcu (.clk(REF_CLK), .line(line), .dim_ch1_in(dim_ch1_in), .dim_ch2_in(dim_ch2_in), .pull_low(pull_low));

  task automatic close_out();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge REF_CLK);
    av.read <= ~w;
    av.write <= w;
    av.address <= a;
    av.writedata <= d;
    // the request stands until waitrequest is seen low; only the watchdog ends a hung wait
    do begin
      @(posedge REF_CLK);
    end while (AV_WAITREQUEST !== 1'b0);
    q = AV_READDATA;
    av.read <= 1'b0;
    av.write <= 1'b0;
  endtask

  task automatic en_pulse();
    @(posedge REF_CLK);
    ctl.en <= 1'b0;
    wt(20);
    ctl.en <= 1'b1;
    wt(10);
  endtask

  // hold channel-1 dimming high long enough to see the sink
  task automatic hold1(input logic e);
    mcu.dim_ch1_in <= 1'b1;
    wt(10);
    `CHK("ch1_sink", e, CH1_SINK)
    mcu.dim_ch1_in <= 1'b0;
    wt(10);
  endtask

  initial begin : watchdog
    wt(60000);
    n_errors++;
    close_out();
  end

  initial begin
    wt(6);
    SRST <= 1'b0;
    wt(10);
    `CHK("oe_no_pgood", 1'b1, DIAG_OE)
    `CHK("ramp_en_low", 1'b1, RAMP_GND)
    `CHK("ldo_en_low", 1'b0, LDO_ON)
    ctl.en <= 1'b1;
    wt(10);
    `CHK("ramp_lockout", 1'b1, RAMP_GND)
    ctl.vcc_ok <= 1'b1;
    wt(10);
    `CHK("ramp_run", 1'b0, RAMP_GND)
    `CHK("ldo_run", 1'b1, LDO_ON)
    bus(1'b0, REG_FILT, '0, rd);
    `CHK("filt_reset", 32'h1fc, rd)
    bus(1'b0, 4'hc, '0, rd);
    `CHK("unmapped", 32'h0, rd)
    bus(1'b1, REG_STAT, 32'hffffffff, rd);
    bus(1'b0, REG_STAT, '0, rd);
    `CHK("stat_ro", 32'h400, rd)
    // static levels with the dimming clock idle
    ctl.pgood <= 1'b1;
    wt(10);
    `CHK("pgood_line", 1'b1, line)
    `CHK("diag_out", 1'b0, DIAG_OUT)
    ctl.ot <= 1'b1;
    wt(10);
    `CHK("ot_line", 1'b0, line)
    mcu.send(16'hf111);
    wt(5);
    `CHK("ot_refuse", LDCL_F_NORM, FREQ_SEL)
    ctl.ot <= 1'b0;
    mcu.tie2 <= 1'b0;
    mcu.dim_ch2_in_lvl <= 1'b1;
    wt(10);
    `CHK("ch2_alone", 1'b1, CH2_SINK)
    `CHK("ch1_idle", 1'b0, CH1_SINK)
    `CHK("line_idle", 1'b1, line)
    mcu.dim_ch2_in_lvl <= 1'b0;
    mcu.tie2 <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      mcu.send(cmd[i]);
      wt(5);
      `CHK("freq", fexp[i], FREQ_SEL)
    end
    hold1(1'b1);
    mcu.send(16'hf555);
    wt(5);
    hold1(1'b0);
    bus(1'b0, REG_STAT, '0, rd);
    `CHK("ch1_off", 1'b1, rd[7])
    mcu.send(16'hf333);
    en_pulse();
    `CHK("freq_back", LDCL_F_NORM, FREQ_SEL)
    hold1(1'b1);
    ctl.tsd <= 1'b1;
    wt(10);
    `CHK("tsd_ldo", 1'b0, LDO_ON)
    `CHK("tsd_ramp", 1'b1, RAMP_GND)
    ctl.tsd <= 1'b0;
    wt(10);
    `CHK("tsd_ldo_back", 1'b1, LDO_ON)
    `CHK("tsd_ramp_back", 1'b0, RAMP_GND)
    ctl.vcc_ok <= 1'b0;
    wt(10);
    `CHK("uv_ramp", 1'b1, RAMP_GND)
    ctl.vcc_ok <= 1'b1;
    wt(10);
    // short persistence count keeps the fault runs brief
    bus(1'b1, REG_FILT, 32'h3, rd);
    for (int i = 0; i < 4; i++) begin
      ctl[3:0] <= 4'h8 >> i;
      wt(10);
      mcu.recv(3, r);
      mcu.recv(8, r);
      `CHK("pattern", {pat[i], pat[i]}, r)
      ctl[3:0] <= 4'h0;
      mcu.send(16'hf111);
      wt(5);
      `CHK("pat_refuse", LDCL_F_NORM, FREQ_SEL)
      ctl.ot <= 1'b1;
      mcu.recv(4, r);
      `CHK("ot_hides", 8'h00, r)
      ctl.ot <= 1'b0;
      wt(10);
      bus(1'b0, REG_STAT, '0, rd);
      `CHK("pat_back", {1'b1, pat[i]}, rd[4:0])
      if (i[0]) bus(1'b1, REG_CTRL, 32'h1, rd);
      else en_pulse();
      mcu.recv(4, r);
      `CHK("pat_gone", 8'h0f, r)
    end
    close_out();
  end
endmodule // test_led_driver_diag_command_link
`default_nettype wire
